//--- verilog/ufsp_pkg.sv
/*
  Constants, carrier struct and state types for the user flash serial port.
  Assumes a 200 MHz core clock; all timing counts derive from it.
*/
package ufsp_pkg;

  // ----------------------------------------------------------------
  // store geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;
  localparam int WORDS  = 512;
  localparam int SECTOR_BIT = 8;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic [8:0]  ADDR_RST    = 9'h000;
  localparam logic [15:0] DATA_RST    = 16'h0000;
  localparam logic [8:0]  ADDR_STEP   = 9'h001;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 5;
  localparam int PROG_TIME_NS   = 1000;
  localparam int ERASE_TIME_NS  = 20000;
  localparam int RING_HALF_NS   = 100;
  localparam int LIVE_WAIT_MS   = 500;
  localparam int REPROG_TIME_NS = 5000;
  localparam int PROG_CYCLES    = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES   = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RING_HALF_CYCLES = RING_HALF_NS / CLK_PERIOD_NS;
  localparam int LIVE_WAIT_CYCLES = (LIVE_WAIT_MS * 1000000) / CLK_PERIOD_NS;
  localparam int REPROG_CYCLES  = (REPROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEQ_CNT_W      = 12;
  localparam int RING_CNT_W     = 5;
  localparam int LIVE_CNT_W     = 32;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam int AV_ADDR_W = 4;
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_ADDR   = 4'h8;
  localparam logic [3:0] REG_DATA   = 4'hc;
  localparam int CTRL_LIVE_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_LIVE_BIT = 1;
  localparam int STAT_REPROG_BIT = 2;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // carrier and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic data_serial_in;
    logic data_shift_clock;
    logic data_shift_select;
    logic addr_serial_in;
    logic addr_shift_clock;
    logic addr_shift_select;
    logic program_request;
    logic erase_request;
    logic ring_clock_enable;
  } ufsp_pins_type;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_PROGRAM, SEQ_ERASE} ufsp_seq_type;
  typedef enum logic [1:0] {LIVE_OFF, LIVE_RUN, LIVE_REPROG} ufsp_live_type;

endpackage

//--- verilog/ufsp_top.sv
/*
  User flash serial port: 512 x 16 store in flip-flops, serial address and
  data registers, program / sector-erase sequencer, gated ring clock and a
  live-reprogramming phase started over Avalon-MM.
  Assumes the pin inputs come from logic on another clock; they are
  synchronised and their clock edges found by oversampling at 200 MHz.
*/
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
//
// Contract
// - program edge writes data register into word at current address
// - busy stays high until the program sequence has finished
// - erase edge clears sector chosen by address top bit
// - busy rises when sequencer starts, falls when algorithm ends
// - program or erase requests are ignored while busy
// - ring enable high toggles ring clock, low holds it high; the code also toggles it while reprogramming
// - in shift mode serial out shows new data register top bit
// - in load mode serial out shows top bit of loaded word
// - live flag high; run state kept for 500 ms before reprogramming
// - registers need not survive live reprogramming; user reloads them
// - store is 512 words of 16 bits, two sectors by address top bit
// - address shift mode shifts serial bit in on each clock edge
// - address increment mode adds one on each clock edge
// - all operations target the current address register value
// - data register is 16 bits, shifts from serial in toward out
// - data load mode loads addressed word in parallel
// - loaded words leave most significant bit first
// - internal sequencer times program and erase on its own
// - only whole-sector erase exists
// - address register is 9 bits and wraps to zero
// - shifting takes serial bit into bit 0, bit 15 goes out
`timescale 1ns/1ps
module ufsp_top #(
  parameter int unsigned LIVE_WAIT_CYCLES = ufsp_pkg::LIVE_WAIT_CYCLES,
  parameter int unsigned REPROG_CYCLES    = ufsp_pkg::REPROG_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        clk_en,
  input  wire logic        data_serial_in,
  input  wire logic        data_shift_clock,
  input  wire logic        data_shift_select,
  input  wire logic        addr_serial_in,
  input  wire logic        addr_shift_clock,
  input  wire logic        addr_shift_select,
  input  wire logic        program_request,
  input  wire logic        erase_request,
  input  wire logic        ring_clock_enable,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             data_serial_out,
  output logic             busy,
  output logic             ring_clock_out,
  output logic             live_reprogram_active
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  ufsp_pkg::ufsp_pins_type pins_raw;
  ufsp_pkg::ufsp_pins_type sync1;
  ufsp_pkg::ufsp_pins_type sync2;
  ufsp_pkg::ufsp_pins_type sync3;

  assign pins_raw = '{data_serial_in, data_shift_clock, data_shift_select,
                      addr_serial_in, addr_shift_clock, addr_shift_select,
                      program_request, erase_request, ring_clock_enable};

  always_ff @(posedge clk) begin
    if (srst) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else if (clk_en) begin
      sync1 <= pins_raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  wire dclk_rise  = sync2.data_shift_clock & ~sync3.data_shift_clock;
  wire aclk_rise  = sync2.addr_shift_clock & ~sync3.addr_shift_clock;
  wire prog_rise  = sync2.program_request & ~sync3.program_request;
  wire erase_rise = sync2.erase_request & ~sync3.erase_request;

  // ----------------------------------------------------------------
  // state declarations
  // ----------------------------------------------------------------
  logic [15:0] mem [ufsp_pkg::WORDS];
  logic [8:0]  addr_reg;
  logic [15:0] data_reg;
  logic [8:0]  next_addr;
  logic [15:0] next_data;

  ufsp_pkg::ufsp_seq_type  seq_state;
  ufsp_pkg::ufsp_seq_type  next_seq_state;
  logic [ufsp_pkg::SEQ_CNT_W-1:0] seq_cnt;
  logic [ufsp_pkg::SEQ_CNT_W-1:0] next_seq_cnt;

  ufsp_pkg::ufsp_live_type live_state;
  ufsp_pkg::ufsp_live_type next_live_state;
  logic [ufsp_pkg::LIVE_CNT_W-1:0] live_cnt;
  logic [ufsp_pkg::LIVE_CNT_W-1:0] next_live_cnt;

  logic [ufsp_pkg::RING_CNT_W-1:0] ring_cnt;

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  wire seq_idle    = (seq_state == ufsp_pkg::SEQ_IDLE);
  wire in_reprog   = (live_state == ufsp_pkg::LIVE_REPROG);
  wire start_prog  = prog_rise & seq_idle & ~in_reprog;
  // program wins if both edges land together
  wire start_erase = erase_rise & ~prog_rise & seq_idle & ~in_reprog;
  wire [15:0] word_at_addr = mem[addr_reg];

  // ----------------------------------------------------------------
  // store, one flop row per word
  // ----------------------------------------------------------------
  for (genvar w = 0; w < ufsp_pkg::WORDS; w++) begin : g_word
    wire word_sector = (w >= ufsp_pkg::WORDS / 2);
    wire hit_prog    = start_prog & (addr_reg == ufsp_pkg::ADDR_W'(w));
    wire hit_erase   = start_erase & (addr_reg[ufsp_pkg::SECTOR_BIT] == word_sector);
    always_ff @(posedge clk) begin
      if (srst) begin
        mem[w] <= ufsp_pkg::ERASED_WORD;
      end else if (clk_en) begin
        if (hit_prog) begin
          mem[w] <= data_reg;
        end else if (hit_erase) begin
          mem[w] <= ufsp_pkg::ERASED_WORD;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // address and data registers
  // ----------------------------------------------------------------
  // serial address shift
  wire [8:0] addr_shifted = {addr_reg[7:0], sync2.addr_serial_in};
  wire [8:0] addr_incr    = addr_reg + ufsp_pkg::ADDR_STEP;
  wire [15:0] data_shifted = {data_reg[14:0], sync2.data_serial_in};

  always_comb begin
    next_addr = addr_reg;
    next_data = data_reg;
    if (in_reprog) begin
      next_addr = ufsp_pkg::ADDR_RST;
      next_data = ufsp_pkg::DATA_RST;
    end else begin
      if (aclk_rise) begin
        next_addr = sync2.addr_shift_select ? addr_shifted : addr_incr;
      end
      if (dclk_rise) begin
        next_data = sync2.data_shift_select ? data_shifted : word_at_addr;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      addr_reg        <= ufsp_pkg::ADDR_RST;
      data_reg        <= ufsp_pkg::DATA_RST;
      data_serial_out <= 1'b0;
    end else if (clk_en) begin
      addr_reg        <= next_addr;
      data_reg        <= next_data;
      data_serial_out <= next_data[15];
    end
  end

  // ----------------------------------------------------------------
  // program / erase sequencer
  // ----------------------------------------------------------------
  // self timed steps
  always_comb begin
    next_seq_state = seq_state;
    next_seq_cnt   = seq_cnt;
    case (seq_state)
      ufsp_pkg::SEQ_IDLE: begin
        if (start_prog) begin
          next_seq_state = ufsp_pkg::SEQ_PROGRAM;
          next_seq_cnt   = ufsp_pkg::SEQ_CNT_W'(ufsp_pkg::PROG_CYCLES - 1);
        end else if (start_erase) begin
          next_seq_state = ufsp_pkg::SEQ_ERASE;
          next_seq_cnt   = ufsp_pkg::SEQ_CNT_W'(ufsp_pkg::ERASE_CYCLES - 1);
        end
      end
      ufsp_pkg::SEQ_PROGRAM, ufsp_pkg::SEQ_ERASE: begin
        if (seq_cnt == '0) begin
          next_seq_state = ufsp_pkg::SEQ_IDLE;
        end else begin
          next_seq_cnt = seq_cnt - 1'b1;
        end
      end
      default: begin
        next_seq_state = ufsp_pkg::SEQ_IDLE;
        next_seq_cnt   = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      seq_state <= ufsp_pkg::SEQ_IDLE;
      seq_cnt   <= '0;
      busy      <= 1'b0;
    end else if (clk_en) begin
      seq_state <= next_seq_state;
      seq_cnt   <= next_seq_cnt;
      busy      <= (next_seq_state != ufsp_pkg::SEQ_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // live reprogramming
  // ----------------------------------------------------------------
  wire av_take  = (avs_read | avs_write) & ~avs_waitrequest;
  wire live_go  = av_take & avs_write & (avs_address == ufsp_pkg::REG_CTRL)
                  & avs_writedata[ufsp_pkg::CTRL_LIVE_BIT];

  always_comb begin
    next_live_state = live_state;
    next_live_cnt   = live_cnt;
    case (live_state)
      ufsp_pkg::LIVE_OFF: begin
        if (live_go) begin
          next_live_state = ufsp_pkg::LIVE_RUN;
          next_live_cnt   = ufsp_pkg::LIVE_CNT_W'(LIVE_WAIT_CYCLES - 1);
        end
      end
      ufsp_pkg::LIVE_RUN: begin
        if (live_cnt == '0) begin
          next_live_state = ufsp_pkg::LIVE_REPROG;
          next_live_cnt   = ufsp_pkg::LIVE_CNT_W'(REPROG_CYCLES - 1);
        end else begin
          next_live_cnt = live_cnt - 1'b1;
        end
      end
      ufsp_pkg::LIVE_REPROG: begin
        if (live_cnt == '0) begin
          next_live_state = ufsp_pkg::LIVE_OFF;
        end else begin
          next_live_cnt = live_cnt - 1'b1;
        end
      end
      default: begin
        next_live_state = ufsp_pkg::LIVE_OFF;
        next_live_cnt   = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      live_state            <= ufsp_pkg::LIVE_OFF;
      live_cnt              <= '0;
      live_reprogram_active <= 1'b0;
    end else if (clk_en) begin
      live_state            <= next_live_state;
      live_cnt              <= next_live_cnt;
      live_reprogram_active <= (next_live_state != ufsp_pkg::LIVE_OFF);
    end
  end

  // ----------------------------------------------------------------
  // ring clock
  // ----------------------------------------------------------------
  // oscillator also self-enables while reprogramming
  wire ring_run  = sync2.ring_clock_enable | in_reprog;
  wire ring_wrap = (ring_cnt == ufsp_pkg::RING_CNT_W'(ufsp_pkg::RING_HALF_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (srst) begin
      ring_cnt       <= '0;
      ring_clock_out <= 1'b1;
    end else if (clk_en) begin
      if (!ring_run) begin
        ring_cnt       <= '0;
        ring_clock_out <= 1'b1;
      end else if (ring_wrap) begin
        ring_cnt       <= '0;
        ring_clock_out <= ~ring_clock_out;
      end else begin
        ring_cnt <= ring_cnt + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  wire [31:0] rd_status = {29'h0000_0000, in_reprog, live_reprogram_active, busy};
  wire [31:0] rd_addr   = {23'h00_0000, addr_reg};
  wire [31:0] rd_data   = {16'h0000, data_reg};
  wire [31:0] rd_mux    = (avs_address == ufsp_pkg::REG_STATUS) ? rd_status :
                          (avs_address == ufsp_pkg::REG_ADDR)   ? rd_addr   :
                          (avs_address == ufsp_pkg::REG_DATA)   ? rd_data   :
                          ufsp_pkg::RDATA_RST;

  always_ff @(posedge clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= ufsp_pkg::RDATA_RST;
    end else if (clk_en) begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence seq_run_s;
    busy && !seq_idle;
  endsequence

  sequence live_wait_s;
    live_reprogram_active && (live_state == ufsp_pkg::LIVE_RUN);
  endsequence

  prog_write_a: assert property (clk_en && start_prog |=>
    mem[$past(addr_reg)] == $past(data_reg)) else $error("program did not store word");

  prog_busy_a: assert property (clk_en && start_prog |=> seq_run_s [*2])
    else $error("busy not held after program start");

  erase_sector_a: assert property (clk_en && start_erase |=>
    mem[{$past(addr_reg[8]), 8'h00}] == ufsp_pkg::ERASED_WORD &&
    mem[{$past(addr_reg[8]), 8'hff}] == ufsp_pkg::ERASED_WORD)
    else $error("sector not erased");

  busy_end_a: assert property (clk_en && !seq_idle && seq_cnt == '0 |=> !busy)
    else $error("busy not dropped at sequence end");

  no_restart_a: assert property (clk_en && !seq_idle && seq_cnt != '0 |=>
    seq_cnt == $past(seq_cnt) - 1'b1) else $error("request restarted sequencer");

  ring_hold_a: assert property (clk_en && !ring_run |=> ring_clock_out)
    else $error("ring clock not held high");

  shift_out_a: assert property (clk_en && !in_reprog && dclk_rise &&
    sync2.data_shift_select |=> data_serial_out == $past(data_reg[14]) &&
    data_reg[0] == $past(sync2.data_serial_in)) else $error("shift output wrong");

  load_out_a: assert property (clk_en && !in_reprog && dclk_rise &&
    !sync2.data_shift_select |=> data_reg == $past(word_at_addr) &&
    data_serial_out == data_reg[15]) else $error("load output wrong");

  addr_shift_a: assert property (clk_en && !in_reprog && aclk_rise &&
    sync2.addr_shift_select |=> addr_reg == {$past(addr_reg[7:0]),
    $past(sync2.addr_serial_in)}) else $error("address shift wrong");

  addr_incr_a: assert property (clk_en && !in_reprog && aclk_rise &&
    !sync2.addr_shift_select |=> addr_reg == 9'($past(addr_reg) + 9'h001))
    else $error("address increment wrong");

  live_run_a: assert property (clk_en && live_go && live_state == ufsp_pkg::LIVE_OFF
    && LIVE_WAIT_CYCLES > 2 |=> live_wait_s [*2]) else $error("live run phase skipped");

  reprog_clear_a: assert property (clk_en && in_reprog |=>
    addr_reg == ufsp_pkg::ADDR_RST && data_reg == ufsp_pkg::DATA_RST)
    else $error("registers kept through reprogramming");

endmodule

//--- tb/ufsp_user_model.sv
/*
  Behavioural user logic driving the pin side of the flash serial port.
  Assumes the bench calls its tasks; shift clocks run at 125 ns in frames only.
*/
`timescale 1ns/1ps
module ufsp_user_model (
  input  wire logic               clk,
  input  wire logic               busy,
  input  wire logic               live_reprogram_active,
  input  wire logic               data_serial_out,
  output ufsp_pkg::ufsp_pins_type pins
);
  localparam realtime HALF = 62.5;
  logic [15:0] seen;
  logic        last;

  initial begin
    pins = '0;
    seen = '0;
    last = 1'b0;
  end

  // no frame while busy or live
  task automatic wait_idle();
    while (busy !== 1'b0 || live_reprogram_active !== 1'b0) @(posedge clk);
    @(posedge clk);
    #1.3;
  endtask

  // ----------------------------------------------------------------
  // one shift clock period, output sampled before the fall
  // ----------------------------------------------------------------
  task automatic tick(input bit adr);
    #HALF;
    if (adr) begin
      pins.addr_shift_clock = 1'b1;
    end else begin
      pins.data_shift_clock = 1'b1;
    end
    #HALF;
    last = data_serial_out;
    pins.addr_shift_clock = 1'b0;
    pins.data_shift_clock = 1'b0;
  endtask

  task automatic shift_addr(input logic [8:0] a);
    wait_idle();
    pins.addr_shift_select = 1'b1;
    for (int i = 8; i >= 0; i--) begin
      pins.addr_serial_in = a[i];
      tick(1'b1);
    end
    pins.addr_serial_in = ~a[0];
  endtask

  task automatic addr_inc(input int n);
    wait_idle();
    pins.addr_shift_select = 1'b0;
    repeat (n) tick(1'b1);
  endtask

  task automatic shift_data(input logic [15:0] d);
    wait_idle();
    pins.data_shift_select = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      pins.data_serial_in = d[i];
      tick(1'b0);
      seen[i] = last;
    end
    pins.data_serial_in = ~d[0];
  endtask

  task automatic load_word();
    wait_idle();
    pins.data_shift_select = 1'b0;
    tick(1'b0);
  endtask

  task automatic set_req(input bit er, input bit v);
    #1;
    if (er) begin
      pins.erase_request = v;
    end else begin
      pins.program_request = v;
    end
  endtask

  task automatic set_ring(input bit v);
    #1;
    pins.ring_clock_enable = v;
  endtask
endmodule

//--- tb/tb_top.sv
/*
  Self-checking bench for the flash serial port with a word-level store model.
  Assumes the design package and the user logic model are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  localparam int LW = 50;
  localparam int RP = 20;
  logic                    clk, clk_en, srst, avs_read, avs_write, avs_waitrequest;
  logic [3:0]              avs_address;
  logic [31:0]             avs_writedata, avs_readdata, rd, tmp;
  logic                    data_serial_out, busy, ring_clock_out, live_reprogram_active;
  ufsp_pkg::ufsp_pins_type pins;
  int                      fail_count, check_count, n;
  time                     t0;
  logic [31:0]             seed;
  logic [15:0]             mem [512];
  logic [8:0]              mdl_addr;
  logic [15:0]             mdl_data;
  logic [8:0]              used [$];

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ufsp_top #(.LIVE_WAIT_CYCLES(LW), .REPROG_CYCLES(RP)) dut (
    .clk(clk), .srst(srst), .clk_en(clk_en),
    .data_serial_in(pins.data_serial_in), .data_shift_clock(pins.data_shift_clock),
    .data_shift_select(pins.data_shift_select), .addr_serial_in(pins.addr_serial_in),
    .addr_shift_clock(pins.addr_shift_clock), .addr_shift_select(pins.addr_shift_select),
    .program_request(pins.program_request), .erase_request(pins.erase_request),
    .ring_clock_enable(pins.ring_clock_enable), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .data_serial_out(data_serial_out), .busy(busy), .ring_clock_out(ring_clock_out),
    .live_reprogram_active(live_reprogram_active));

  ufsp_user_model user (
    .clk(clk), .busy(busy), .live_reprogram_active(live_reprogram_active),
    .data_serial_out(data_serial_out), .pins(pins));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic av_xfer(input logic [3:0] a, input bit wr, input logic [31:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= ~wr;
    avs_write     <= wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic send_data(input logic [15:0] d);
    user.shift_data(d);
    for (int i = 15; i >= 0; i--) begin
      mdl_data = {mdl_data[14:0], d[i]};
      chk(32'(user.seen[i]), 32'(mdl_data[15]), "shifted bit");
    end
    av_xfer(ufsp_pkg::REG_DATA, 1'b0, 32'h0000_0000);
    chk(rd, {16'h0000, mdl_data}, "data register");
  endtask

  task automatic set_addr(input logic [8:0] a);
    user.shift_addr(a);
    mdl_addr = a;
    av_xfer(ufsp_pkg::REG_ADDR, 1'b0, 32'h0000_0000);
    chk(rd, {23'h0, a}, "address register");
  endtask

  task automatic rd_here();
    user.load_word();
    mdl_data = mem[mdl_addr];
    chk(32'(user.last), 32'(mdl_data[15]), "loaded top bit");
    tmp = xs();
    send_data(tmp[15:0]);
  endtask

  task automatic do_op(input bit er, input bit poke);
    int w;
    user.set_req(er, 1'b1);
    w = 0;
    while (busy !== 1'b1 && w < 20) begin
      @(posedge clk);
      w++;
    end
    chk(32'(busy), 32'h1, "busy rise");
    w = 0;
    while (busy === 1'b1 && w < 5000) begin
      @(posedge clk);
      w++;
      if (w == 5) user.set_req(er, 1'b0);
      if (poke && w == 40) user.set_req(!er, 1'b1);
      if (poke && w == 60) user.set_req(!er, 1'b0);
    end
    n = er ? ufsp_pkg::ERASE_CYCLES : ufsp_pkg::PROG_CYCLES;
    chk(32'(w >= n && w <= n + 2), 32'h1, "busy length");
    repeat (10) @(posedge clk);
    chk(32'(busy), 32'h0, "request during busy");
  endtask

  task automatic ring_idle();
    n = 0;
    repeat (40) begin
      @(posedge clk);
      if (ring_clock_out !== 1'b1) n++;
    end
    chk(n, 0, "ring held high");
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // watchdog at about four times the expected run
  initial begin
    #400_000;
    fail_count++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'hdc8d_d4c3;
    fail_count = 0;
    check_count = 0;
    srst = 1'b1;
    clk_en = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    foreach (mem[i]) mem[i] = 16'hffff;
    mdl_addr = '0;
    mdl_data = '0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    chk({busy, live_reprogram_active, ring_clock_out}, 32'h1, "reset outputs");
    av_xfer(ufsp_pkg::REG_STATUS, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "status after reset");
    av_xfer(4'h2, 1'b1, xs());
    av_xfer(4'h2, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "unmapped read");
    rd_here();
    for (int k = 0; k < 6; k++) begin
      tmp = xs();
      set_addr(k == 0 ? 9'h1ff : k == 1 ? 9'h0ff : tmp[8:0]);
      send_data(tmp[31:16]);
      do_op(1'b0, k == 2);
      mem[mdl_addr] = tmp[31:16];
      used.push_back(mdl_addr);
    end
    foreach (used[i]) begin
      set_addr(used[i]);
      rd_here();
    end
    set_addr(9'h1fe);
    user.addr_inc(2);
    mdl_addr = mdl_addr + 9'h002;
    av_xfer(ufsp_pkg::REG_ADDR, 1'b0, 32'h0000_0000);
    chk(rd, {23'h0, mdl_addr}, "address wrap");
    rd_here();
    tmp = xs();
    set_addr({1'b1, tmp[7:0]});
    do_op(1'b1, 1'b1);
    for (int i = 256; i < 512; i++) mem[i] = 16'hffff;
    foreach (used[i]) begin
      set_addr(used[i]);
      rd_here();
    end
    user.set_ring(1'b0);
    ring_idle();
    user.set_ring(1'b1);
    n = 0;
    tmp[0] = ring_clock_out;
    repeat (400) begin
      @(posedge clk);
      if (ring_clock_out !== tmp[0]) n++;
      tmp[0] = ring_clock_out;
    end
    chk(32'(n >= 18 && n <= 21), 32'h1, "ring toggles");
    clk_en <= 1'b0;
    @(posedge clk);
    tmp[0] = ring_clock_out;
    n = 0;
    repeat (60) begin
      @(posedge clk);
      if (ring_clock_out !== tmp[0]) n++;
    end
    clk_en <= 1'b1;
    chk(n, 0, "clock enable freeze");
    user.set_ring(1'b0);
    repeat (30) @(posedge clk);
    ring_idle();
    av_xfer(ufsp_pkg::REG_CTRL, 1'b1, 32'h0000_0001);
    n = 0;
    while (live_reprogram_active !== 1'b1 && n < 10) begin
      @(posedge clk);
      n++;
    end
    t0 = $time;
    chk(32'(live_reprogram_active), 32'h1, "live flag rise");
    av_xfer(ufsp_pkg::REG_STATUS, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0002, "live run status");
    repeat (LW) @(posedge clk);
    av_xfer(ufsp_pkg::REG_STATUS, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0006, "reprogram status");
    n = 0;
    while (live_reprogram_active === 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    n = int'(($time - t0) / ufsp_pkg::CLK_PERIOD_NS);
    chk(32'(n >= LW + RP - 10 && n <= LW + RP + 10), 32'h1, "live length");
    av_xfer(ufsp_pkg::REG_ADDR, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "address after live");
    av_xfer(ufsp_pkg::REG_DATA, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "data after live");
    mdl_data = '0;
    set_addr(used[0]);
    rd_here();
    give_verdict();
  end
endmodule
